/* File: jdp_pkg.sv */
package jdp_pkg;

  localparam int IR_W = 4;
  localparam int DR_W = 32;
  localparam int TAP_N = 3;
  localparam int BSCAN_N = 2;
  localparam int PIN_N = 32;

  localparam logic [3:0] IR_EXTEST = 4'h0;
  localparam logic [3:0] IR_DEVICE_ID_CAPTURE = 4'h1;
  localparam logic [3:0] IR_SAMPLE = 4'h2;
  localparam logic [3:0] IR_USERCODE = 4'h3;
  localparam logic [3:0] IR_LOAD = 4'h4;
  localparam logic [3:0] IR_DBGREQ = 4'h5;
  localparam logic [3:0] IR_OTPADDR = 4'h6;
  localparam logic [3:0] IR_OTPDATA = 4'h7;
  localparam logic [3:0] IR_STATUS = 4'h9;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAP_PAT = 4'h1;
  localparam logic [3:0] IR_RESET = IR_DEVICE_ID_CAPTURE;

  // Security register bit positions
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_OTP_OFF = 13;
  localparam int SEC_DBG_OFF = 14;
  localparam int SEC_TAG_LSB = 22;
  localparam int SEC_TAG_MSB = 31;

  // Identification word layout
  localparam int ID_VER_W = 4;
  localparam int ID_PART_W = 16;
  localparam int ID_MFR_W = 11;
  localparam int UC_UNUSED_W = 6;
  localparam int UC_REV_W = 16;

  localparam int OTP_AW = 11;

  localparam int RST_INIT_US = 150;
  localparam int MCLK_MHZ = 250;
  localparam int INIT_CYC = RST_INIT_US * MCLK_MHZ;
  localparam int INIT_CW = 16;

  typedef enum logic [3:0] {
    TS_RESET = 4'h0, TS_IDLE = 4'h1, TS_SEL_DR = 4'h3, TS_CAP_DR = 4'h2,
    TS_SH_DR = 4'h6, TS_EX1_DR = 4'h7, TS_PA_DR = 4'h5, TS_EX2_DR = 4'h4,
    TS_UPD_DR = 4'hC, TS_SEL_IR = 4'hD, TS_CAP_IR = 4'hF, TS_SH_IR = 4'hE,
    TS_EX1_IR = 4'hA, TS_PA_IR = 4'hB, TS_EX2_IR = 4'h9, TS_UPD_IR = 4'h8
  } jdp_tap_st_type;

  typedef enum logic [1:0] {
    BOOT_HOLD = 2'h0, BOOT_LOCK = 2'h1, BOOT_RUN = 2'h3
  } jdp_boot_st_type;

  typedef struct packed {
    logic [3:0] ir;
    logic [31:0] dr;
    logic upd_dr;
  } jdp_tap_out_type;

  typedef struct packed {
    logic [31:0] sec;
    logic [31:0] otp;
    logic booted;
    logic halted;
  } jdp_xdom_type;

  typedef struct packed {
    logic load;
    logic dbgreq;
    logic otp;
  } jdp_evt_type;

endpackage

/* File: jdp_sync.sv */
`timescale 1ns/1ps
module jdp_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= '0;
      q_o <= '0;
    end else begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end

endmodule

/* File: jdp_tap.sv */
`timescale 1ns/1ps
module jdp_tap (
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic [31:0] cap_i,
  input wire logic byp_i,
  output logic tdo_o,
  output jdp_pkg::jdp_tap_out_type out_o
);

  jdp_pkg::jdp_tap_st_type st_ff;
  jdp_pkg::jdp_tap_st_type nxt_st;
  logic [3:0] ir_sh_ff;
  logic [3:0] ir_ff;
  logic [31:0] dr_sh_ff;

  always_comb begin
    case (st_ff)
      jdp_pkg::TS_RESET: nxt_st = tms_i ? jdp_pkg::TS_RESET : jdp_pkg::TS_IDLE;
      jdp_pkg::TS_IDLE: nxt_st = tms_i ? jdp_pkg::TS_SEL_DR : jdp_pkg::TS_IDLE;
      jdp_pkg::TS_SEL_DR: nxt_st = tms_i ? jdp_pkg::TS_SEL_IR : jdp_pkg::TS_CAP_DR;
      jdp_pkg::TS_CAP_DR: nxt_st = tms_i ? jdp_pkg::TS_EX1_DR : jdp_pkg::TS_SH_DR;
      jdp_pkg::TS_SH_DR: nxt_st = tms_i ? jdp_pkg::TS_EX1_DR : jdp_pkg::TS_SH_DR;
      jdp_pkg::TS_EX1_DR: nxt_st = tms_i ? jdp_pkg::TS_UPD_DR : jdp_pkg::TS_PA_DR;
      jdp_pkg::TS_PA_DR: nxt_st = tms_i ? jdp_pkg::TS_EX2_DR : jdp_pkg::TS_PA_DR;
      jdp_pkg::TS_EX2_DR: nxt_st = tms_i ? jdp_pkg::TS_UPD_DR : jdp_pkg::TS_SH_DR;
      jdp_pkg::TS_UPD_DR: nxt_st = tms_i ? jdp_pkg::TS_SEL_DR : jdp_pkg::TS_IDLE;
      jdp_pkg::TS_SEL_IR: nxt_st = tms_i ? jdp_pkg::TS_RESET : jdp_pkg::TS_CAP_IR;
      jdp_pkg::TS_CAP_IR: nxt_st = tms_i ? jdp_pkg::TS_EX1_IR : jdp_pkg::TS_SH_IR;
      jdp_pkg::TS_SH_IR: nxt_st = tms_i ? jdp_pkg::TS_EX1_IR : jdp_pkg::TS_SH_IR;
      jdp_pkg::TS_EX1_IR: nxt_st = tms_i ? jdp_pkg::TS_UPD_IR : jdp_pkg::TS_PA_IR;
      jdp_pkg::TS_PA_IR: nxt_st = tms_i ? jdp_pkg::TS_EX2_IR : jdp_pkg::TS_PA_IR;
      jdp_pkg::TS_EX2_IR: nxt_st = tms_i ? jdp_pkg::TS_UPD_IR : jdp_pkg::TS_SH_IR;
      jdp_pkg::TS_UPD_IR: nxt_st = tms_i ? jdp_pkg::TS_SEL_DR : jdp_pkg::TS_IDLE;
      default: nxt_st = jdp_pkg::TS_RESET;
    endcase
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      st_ff <= jdp_pkg::TS_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      ir_sh_ff <= jdp_pkg::IR_CAP_PAT;
      ir_ff <= jdp_pkg::IR_RESET;
    end else begin
      case (st_ff)
        jdp_pkg::TS_RESET: ir_ff <= jdp_pkg::IR_RESET;
        jdp_pkg::TS_CAP_IR: ir_sh_ff <= jdp_pkg::IR_CAP_PAT;
        jdp_pkg::TS_SH_IR: ir_sh_ff <= {tdi_i, ir_sh_ff[3:1]};
        jdp_pkg::TS_UPD_IR: ir_ff <= ir_sh_ff;
        default: ir_ff <= ir_ff;
      endcase
    end
  end

  // Bypass shortens the path to one cell, bit 0 of the shifter
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      dr_sh_ff <= 32'h0;
    end else if (st_ff == jdp_pkg::TS_CAP_DR) begin
      dr_sh_ff <= byp_i ? 32'h0 : cap_i;
    end else if (st_ff == jdp_pkg::TS_SH_DR) begin
      if (byp_i) begin
        dr_sh_ff[0] <= tdi_i;
      end else begin
        dr_sh_ff <= {tdi_i, dr_sh_ff[31:1]};
      end
    end
  end

  // Falling edge launch gives the next stage a half period of setup
  always_ff @(negedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      tdo_o <= 1'b0;
    end else if (st_ff == jdp_pkg::TS_SH_IR) begin
      tdo_o <= ir_sh_ff[0];
    end else if (st_ff == jdp_pkg::TS_SH_DR) begin
      tdo_o <= dr_sh_ff[0];
    end
  end

  assign out_o.ir = ir_ff;
  assign out_o.dr = dr_sh_ff;
  assign out_o.upd_dr = (st_ff == jdp_pkg::TS_UPD_DR);

endmodule

/* File: jdp_top.sv */
`timescale 1ns/1ps
module jdp_top #(
  parameter int unsigned INIT_CYCLES = jdp_pkg::INIT_CYC,
  parameter logic [3:0] ID_VERSION = 4'h1, // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h0A5C, // Arbitrary value
  parameter logic [10:0] ID_MFR = 11'h2B1, // Arbitrary value
  parameter logic [15:0] SI_REV = 16'h0001 // Arbitrary value
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  input wire logic [63:0] pin_in_i,
  output wire logic [63:0] pin_out_o,
  output wire logic [63:0] pin_oen_o,
  input wire logic [31:0] sec_reg_i,
  input wire logic pll_lock_i,
  input wire logic [2:0] boot_mode_i,
  output logic boot_start_o,
  output logic [2:0] boot_mode_o,
  output logic code_wr_valid_o,
  output logic [31:0] code_wr_data_o,
  output logic otp_rd_o,
  output logic [10:0] otp_addr_o,
  input wire logic [31:0] otp_rdata_i,
  input wire logic otp_rvalid_i,
  input wire logic dbg_out_en_i,
  input wire logic dbg_in_en_i,
  input wire logic bkpt_hit_i,
  input wire logic dbg_exit_i,
  input wire logic debug_n_i,
  output logic debug_n_o,
  output logic debug_n_oen_o,
  output logic debug_enter_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Test clock domain: chain of three TAPs

  jdp_pkg::jdp_tap_out_type tap_out [3];
  logic [3:0] chain;
  logic [63:0] pin_s;
  jdp_pkg::jdp_xdom_type xd_m;
  jdp_pkg::jdp_xdom_type xd_s;
  logic jtag_off;
  logic otp_off;
  logic [31:0] id_word;
  logic [31:0] uc_word;
  logic [31:0] load_data_ff;
  logic [10:0] otp_addr_t_ff;
  jdp_pkg::jdp_evt_type evt_t_ff;

  jdp_sync #(.W(64)) u_pin_sync (
    .clk_i(tck_i),
    .rstn_i(trst_n_i),
    .d_i(pin_in_i),
    .q_o(pin_s)
  );

  // Status words are quasi-static, so a per-bit pair of flops is enough
  jdp_sync #(.W(66)) u_xd_sync (
    .clk_i(tck_i),
    .rstn_i(trst_n_i),
    .d_i(xd_m),
    .q_o(xd_s)
  );

  assign jtag_off = xd_s.sec[jdp_pkg::SEC_JTAG_OFF];
  assign otp_off = xd_s.sec[jdp_pkg::SEC_OTP_OFF];
  assign id_word = {ID_VERSION, ID_PART, ID_MFR, 1'b1};
  assign uc_word = {xd_s.sec[jdp_pkg::SEC_TAG_MSB:jdp_pkg::SEC_TAG_LSB],
                    6'h00, SI_REV};
  assign chain[0] = tdi_i;
  assign tdo_o = chain[3];

  genvar g;
  generate
    for (g = 0; g < jdp_pkg::TAP_N; g++) begin : g_tap
      logic [31:0] cap;
      logic byp;

      if (g < jdp_pkg::BSCAN_N) begin : g_bscan
        logic [31:0] upd_ff;
        logic scan_ir;

        assign scan_ir = (tap_out[g].ir == jdp_pkg::IR_EXTEST) ||
                         (tap_out[g].ir == jdp_pkg::IR_SAMPLE);

        always_comb begin
          case (tap_out[g].ir)
            jdp_pkg::IR_DEVICE_ID_CAPTURE: cap = id_word;
            jdp_pkg::IR_USERCODE: cap = uc_word;
            jdp_pkg::IR_EXTEST: cap = pin_s[g*32 +: 32];
            jdp_pkg::IR_SAMPLE: cap = pin_s[g*32 +: 32];
            default: cap = 32'h0;
          endcase
          byp = !(scan_ir || (tap_out[g].ir == jdp_pkg::IR_DEVICE_ID_CAPTURE) ||
                  (tap_out[g].ir == jdp_pkg::IR_USERCODE));
        end

        // Sample doubles as preload so outputs are set before extest
        always_ff @(posedge tck_i or negedge trst_n_i) begin
          if (!trst_n_i) begin
            upd_ff <= 32'h0;
          end else if (tap_out[g].upd_dr && scan_ir) begin
            upd_ff <= tap_out[g].dr;
          end
        end

        assign pin_out_o[g*32 +: 32] = upd_ff;
        assign pin_oen_o[g*32 +: 32] = {32{tap_out[g].ir != jdp_pkg::IR_EXTEST}};
      end else begin : g_chip
        always_comb begin
          byp = 1'b0;
          case (tap_out[g].ir)
            jdp_pkg::IR_DEVICE_ID_CAPTURE: cap = id_word;
            jdp_pkg::IR_USERCODE: cap = uc_word;
            jdp_pkg::IR_STATUS: cap = {30'h0, xd_s.booted, xd_s.halted};
            jdp_pkg::IR_OTPDATA: cap = otp_off ? 32'h0 : xd_s.otp;
            jdp_pkg::IR_LOAD: cap = 32'h0;
            jdp_pkg::IR_DBGREQ: cap = 32'h0;
            jdp_pkg::IR_OTPADDR: cap = 32'h0;
            default: begin
              cap = 32'h0;
              byp = 1'b1;
            end
          endcase
          // Locked parts keep only the identity words readable on the chip TAP; scan TAPs ignore the lock
          if (jtag_off && (tap_out[g].ir != jdp_pkg::IR_DEVICE_ID_CAPTURE) &&
              (tap_out[g].ir != jdp_pkg::IR_USERCODE)) begin
            byp = 1'b1;
          end
        end
      end

      jdp_tap u_tap (
        .tck_i(tck_i),
        .trst_n_i(trst_n_i),
        .tms_i(tms_i),
        .tdi_i(chain[g]),
        .cap_i(cap),
        .byp_i(byp),
        .tdo_o(chain[g+1]),
        .out_o(tap_out[g])
      );
    end
  endgenerate

  // Chip TAP updates become toggles; data regs hold until the next update
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      evt_t_ff <= '0;
      load_data_ff <= 32'h0;
      otp_addr_t_ff <= 11'h000;
    end else if (tap_out[2].upd_dr && !jtag_off) begin
      case (tap_out[2].ir)
        jdp_pkg::IR_LOAD: begin
          load_data_ff <= tap_out[2].dr;
          evt_t_ff.load <= ~evt_t_ff.load;
        end
        jdp_pkg::IR_DBGREQ: evt_t_ff.dbgreq <= ~evt_t_ff.dbgreq;
        jdp_pkg::IR_OTPADDR: begin
          if (!otp_off) begin
            otp_addr_t_ff <= tap_out[2].dr[10:0];
            evt_t_ff.otp <= ~evt_t_ff.otp;
          end
        end
        default: evt_t_ff <= evt_t_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain: reset, boot sequencing

  logic rst_meta_ff;
  logic srst_n_ff;
  logic [7:0] ms_s;
  logic lock_s;
  logic [2:0] mode_s;
  logic dbg_n_s;
  jdp_pkg::jdp_evt_type evt_s;
  jdp_pkg::jdp_evt_type evt_prev_ff;
  jdp_pkg::jdp_evt_type evt_p;
  jdp_pkg::jdp_boot_st_type boot_st_ff;
  jdp_pkg::jdp_boot_st_type nxt_boot_st;
  logic [15:0] init_cnt_ff;
  logic init_done;
  logic [31:0] otp_hold_ff;

  // Assertion reaches every flop at once; release is aligned to mclk
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta_ff <= 1'b0;
      srst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      srst_n_ff <= rst_meta_ff;
    end
  end

  jdp_sync #(.W(8)) u_ms_sync (
    .clk_i(mclk_i),
    .rstn_i(srst_n_ff),
    .d_i({pll_lock_i, boot_mode_i, debug_n_i, evt_t_ff}),
    .q_o(ms_s)
  );

  assign lock_s = ms_s[7];
  assign mode_s = ms_s[6:4];
  assign dbg_n_s = ms_s[3];
  assign evt_s = ms_s[2:0];
  assign evt_p = evt_s ^ evt_prev_ff;

  always_ff @(posedge mclk_i or negedge srst_n_ff) begin
    if (!srst_n_ff) begin
      evt_prev_ff <= '0;
    end else begin
      evt_prev_ff <= evt_s;
    end
  end

  assign init_done = (init_cnt_ff == 16'(INIT_CYCLES - 1));

  always_comb begin
    case (boot_st_ff)
      jdp_pkg::BOOT_HOLD: nxt_boot_st = jdp_pkg::BOOT_LOCK;
      jdp_pkg::BOOT_LOCK: begin
        // Lock normally ends the wait; the timer caps the start latency
        if (lock_s || init_done) begin
          nxt_boot_st = jdp_pkg::BOOT_RUN;
        end else begin
          nxt_boot_st = jdp_pkg::BOOT_LOCK;
        end
      end
      jdp_pkg::BOOT_RUN: nxt_boot_st = jdp_pkg::BOOT_RUN;
      default: nxt_boot_st = jdp_pkg::BOOT_HOLD;
    endcase
  end

  always_ff @(posedge mclk_i or negedge srst_n_ff) begin
    if (!srst_n_ff) begin
      boot_st_ff <= jdp_pkg::BOOT_HOLD;
    end else begin
      boot_st_ff <= nxt_boot_st;
    end
  end

  always_ff @(posedge mclk_i or negedge srst_n_ff) begin
    if (!srst_n_ff) begin
      init_cnt_ff <= 16'h0000;
    end else if (boot_st_ff == jdp_pkg::BOOT_LOCK && !init_done) begin
      init_cnt_ff <= init_cnt_ff + 16'h0001;
    end
  end

  // Strap is caught after release, when the synchroniser holds it
  always_ff @(posedge mclk_i or negedge srst_n_ff) begin
    if (!srst_n_ff) begin
      boot_mode_o <= 3'h0;
      boot_start_o <= 1'b0;
    end else begin
      if (boot_st_ff == jdp_pkg::BOOT_LOCK && nxt_boot_st == jdp_pkg::BOOT_RUN) begin
        boot_mode_o <= mode_s;
      end
      boot_start_o <= (nxt_boot_st == jdp_pkg::BOOT_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain: code load and one-time memory requests

  always_ff @(posedge mclk_i or negedge srst_n_ff) begin
    if (!srst_n_ff) begin
      code_wr_valid_o <= 1'b0;
      code_wr_data_o <= 32'h0;
      otp_rd_o <= 1'b0;
      otp_addr_o <= 11'h000;
    end else begin
      code_wr_valid_o <= evt_p.load;
      otp_rd_o <= evt_p.otp;
      if (evt_p.load) begin
        code_wr_data_o <= load_data_ff;
      end
      if (evt_p.otp) begin
        otp_addr_o <= otp_addr_t_ff;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge srst_n_ff) begin
    if (!srst_n_ff) begin
      otp_hold_ff <= 32'h0;
    end else if (otp_rvalid_i) begin
      otp_hold_ff <= otp_rdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain: debug synchronisation pin

  logic dbg_allow;
  logic pin_lo_prev_ff;
  logic ext_req;
  logic enter;
  logic bkpt_ff;
  logic halted_ff;
  logic drive_ff;

  assign dbg_allow = ~sec_reg_i[jdp_pkg::SEC_DBG_OFF];
  // Our own low drive must not read back as an external request
  assign ext_req = dbg_in_en_i && dbg_allow && !drive_ff &&
                   !dbg_n_s && !pin_lo_prev_ff;
  assign enter = ext_req || evt_p.dbgreq;

  always_ff @(posedge mclk_i or negedge srst_n_ff) begin
    if (!srst_n_ff) begin
      pin_lo_prev_ff <= 1'b1; // Synchroniser reads low until the pin level arrives
      debug_enter_o <= 1'b0;
    end else begin
      pin_lo_prev_ff <= !dbg_n_s;
      debug_enter_o <= enter;
    end
  end

  // Set wins over clear when hit and exit coincide
  always_ff @(posedge mclk_i or negedge srst_n_ff) begin
    if (!srst_n_ff) begin
      bkpt_ff <= 1'b0;
      halted_ff <= 1'b0;
    end else begin
      if (bkpt_hit_i) begin
        bkpt_ff <= 1'b1;
      end else if (dbg_exit_i) begin
        bkpt_ff <= 1'b0;
      end
      if (bkpt_hit_i || enter) begin
        halted_ff <= 1'b1;
      end else if (dbg_exit_i) begin
        halted_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge srst_n_ff) begin
    if (!srst_n_ff) begin
      drive_ff <= 1'b0;
    end else begin
      drive_ff <= dbg_out_en_i && dbg_allow && bkpt_ff;
    end
  end

  assign debug_n_o = 1'b0;
  assign debug_n_oen_o = ~drive_ff;

  assign xd_m.sec = sec_reg_i;
  assign xd_m.otp = otp_hold_ff;
  assign xd_m.booted = boot_start_o;
  assign xd_m.halted = halted_ff;

endmodule

/* File: jdp_asserts.sv */
`timescale 1ns/1ps
module jdp_asserts #(
  parameter int unsigned INIT_CYCLES = 40
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic trst_n_i,
  input wire logic tdo_o,
  input wire logic [63:0] pin_oen_o,
  input wire logic [31:0] sec_reg_i,
  input wire logic pll_lock_i,
  input wire logic boot_start_o,
  input wire logic code_wr_valid_o,
  input wire logic otp_rd_o,
  input wire logic dbg_out_en_i,
  input wire logic bkpt_hit_i,
  input wire logic debug_n_o,
  input wire logic debug_n_oen_o
);
  // Cycles spent waiting for boot since chip reset release
  int unsigned wait_cnt_ff;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_cnt_ff <= 0;
    end else if (!boot_start_o) begin
      wait_cnt_ff <= wait_cnt_ff + 1;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  sequence s_bkpt;
    bkpt_hit_i && dbg_out_en_i && !sec_reg_i[14] ##1 dbg_out_en_i ##1 dbg_out_en_i;
  endsequence
  property p_bkpt_drive;
    s_bkpt |-> !debug_n_oen_o;
  endproperty
  property p_off_float;
    (!dbg_out_en_i || sec_reg_i[14]) [*3] |-> debug_n_oen_o;
  endproperty
  property p_drive_low;
    !debug_n_oen_o |-> !debug_n_o;
  endproperty
  property p_boot_bound;
    wait_cnt_ff <= INIT_CYCLES + 6;
  endproperty
  property p_boot_lock;
    $rose(pll_lock_i) && !boot_start_o |-> ##[1:6] boot_start_o;
  endproperty
  property p_boot_cause;
    $rose(boot_start_o) |-> $past(pll_lock_i, 2) || wait_cnt_ff >= INIT_CYCLES;
  endproperty
  property p_code_pulse;
    code_wr_valid_o |=> !code_wr_valid_o;
  endproperty
  property p_otp_lock;
    sec_reg_i[13] [*8] |-> !otp_rd_o;
  endproperty
  property p_chain_lock;
    sec_reg_i[0] [*8] |-> !code_wr_valid_o && !otp_rd_o;
  endproperty
  property p_trst;
    !trst_n_i |-> !tdo_o && (&pin_oen_o);
  endproperty
  a_bkpt_drive: assert property (p_bkpt_drive) else $error("pin not driven");
  a_off_float: assert property (p_off_float) else $error("pin driven");
  a_drive_low: assert property (p_drive_low) else $error("pin not low");
  a_boot_bound: assert property (p_boot_bound) else $error("boot late");
  a_boot_lock: assert property (p_boot_lock) else $error("boot late after lock");
  a_boot_cause: assert property (p_boot_cause) else $error("boot early");
  a_code_pulse: assert property (p_code_pulse) else $error("code pulse long");
  a_otp_lock: assert property (p_otp_lock) else $error("memory read");
  a_chain_lock: assert property (p_chain_lock) else $error("tile access");
  a_trst: assert property (p_trst) else $error("test reset ignored");
endmodule

/* File: jdp_probe.sv */
`timescale 1ns/1ps
module jdp_probe (
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  output logic trst_n_o
);
  initial begin
    tck_o = 0;
    tms_o = 1;
    tdi_o = 0;
    // Test clock is idle here, so only a real falling edge resets the TAPs
    trst_n_o = 1;
    #1 trst_n_o = 0;
    #120 trst_n_o = 1;
  end
  // Test clock runs only inside a bit; it stands low between frames
  task automatic bit_io(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #37 tck_o = 1;
    q = tdo_i;
    #40 tck_o = 0;
    #3;
  endtask
  task automatic tlr();
    logic q;
    repeat (5) bit_io(1, 0, q);
    bit_io(0, 0, q);
  endtask
  task automatic set_trst(input logic v);
    trst_n_o = v;
  endtask
  // Starts and ends in Run-Test/Idle
  task automatic scan(input logic ir, input logic [95:0] din, input int n,
                      output logic [95:0] dout);
    logic q;
    dout = '0;
    bit_io(1, 0, q);
    if (ir) begin
      bit_io(1, 0, q);
    end
    bit_io(0, 0, q);
    bit_io(0, 0, q);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1, din[i], q);
      dout[i] = q;
    end
    bit_io(1, 0, q);
    bit_io(0, 0, q);
  endtask
endmodule

/* File: jdp_tb.sv */
`timescale 1ns/1ps
module tb;
  // Arbitrary identity values
  localparam logic [3:0] ID_V = 4'h6;
  localparam logic [15:0] ID_P = 16'hB3C1;
  localparam logic [10:0] ID_M = 11'h155;
  localparam logic [15:0] SI = 16'h0A0B;
  logic mclk_i = 0;
  logic rstn_i = 0;
  logic pll_lock_i = 0;
  logic [31:0] sec_reg_i = 32'h0;
  logic bkpt_hit_i = 0, dbg_exit_i = 0, dbg_out_en_i = 0, dbg_in_en_i = 0, ext_n = 1;
  logic [63:0] pin_in_i = 64'h0;
  logic [2:0] boot_mode_i = 3'h2;
  logic [31:0] otp_rdata_i = 32'h0;
  logic otp_rvalid_i = 0;
  logic tck_i, trst_n_i, tms_i, tdi_i, tdo_o, boot_start_o, code_wr_valid_o, otp_rd_o;
  logic debug_n_o, debug_n_oen_o, debug_enter_o;
  wire [63:0] pin_out_o, pin_oen_o;
  logic [2:0] boot_mode_o;
  logic [31:0] code_wr_data_o;
  logic [10:0] otp_addr_o;
  wire debug_n_i;
  int err_total = 0, cmp_count = 0, cyc = 0, n_evt = 0;
  // Pulled-up wire: low when the design drives or the far end pulls it
  assign debug_n_i = ext_n & (debug_n_oen_o | debug_n_o);
  jdp_top #(.INIT_CYCLES(40), .ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MFR(ID_M), .SI_REV(SI))
    i_jdp_top (.mclk_i, .rstn_i, .tck_i, .trst_n_i, .tms_i, .tdi_i, .tdo_o, .pin_in_i,
    .pin_out_o, .pin_oen_o, .sec_reg_i, .pll_lock_i, .boot_mode_i, .boot_start_o,
    .boot_mode_o, .code_wr_valid_o, .code_wr_data_o, .otp_rd_o, .otp_addr_o, .otp_rdata_i,
    .otp_rvalid_i, .dbg_out_en_i, .dbg_in_en_i, .bkpt_hit_i, .dbg_exit_i, .debug_n_i,
    .debug_n_o, .debug_n_oen_o, .debug_enter_o);
  jdp_probe i_jdp_probe (.tdo_i(tdo_o), .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
    .trst_n_o(trst_n_i));
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  // Counted on the falling edge, away from the launching edge, so each one-cycle pulse is seen once
  always @(negedge mclk_i) begin
    cyc++;
    n_evt += (code_wr_valid_o === 1'b1) + (otp_rd_o === 1'b1) + (debug_enter_o === 1'b1);
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic t_boot();
    repeat (20) @(negedge mclk_i);
    chk("boot", boot_start_o, 0);
    repeat (40) @(negedge mclk_i);
    chk("boot", boot_start_o, 1);
    chk("boot mode", boot_mode_o, 3'h2);
    rstn_i = 0;
    #1 chk("boot", boot_start_o, 0);
    repeat (26) @(negedge mclk_i);
    rstn_i = 1;
    repeat (5) @(negedge mclk_i);
    chk("boot", boot_start_o, 0);
    pll_lock_i = 1;
    repeat (8) @(negedge mclk_i);
    chk("boot", boot_start_o, 1);
    $display("Test boot done");
  endtask
  task automatic t_jtag();
    logic [95:0] d;
    i_jdp_probe.tlr();
    i_jdp_probe.scan(0, 96'h0, 96, d);
    chk("device_id_capture", d, {3{ID_V, ID_P, ID_M, 1'b1}});
    i_jdp_probe.scan(1, 96'hFFF, 12, d);
    chk("ir capture", d[11:0], 12'h111);
    i_jdp_probe.scan(0, 96'h5, 6, d);
    chk("bypass", d[5:3], 3'h5);
    @(negedge mclk_i) sec_reg_i = 32'hA940_0000;
    pin_in_i = 64'h0123_4567_89AB_CDEF;
    i_jdp_probe.scan(1, 96'h333, 12, d);
    i_jdp_probe.scan(0, 96'h0, 96, d);
    chk("usercode", d[31:0], {10'h2A5, 6'h0, SI});
    i_jdp_probe.scan(1, 96'h0, 12, d);
    chk("pin enables", pin_oen_o, 64'h0);
    i_jdp_probe.scan(0, {31'h0, 32'hA5C3_0F96, 32'h3C69_5AE1, 1'b0}, 65, d);
    chk("pin capture", d[64:1], 64'h89AB_CDEF_0123_4567);
    chk("pin out", pin_out_o, 64'h3C69_5AE1_A5C3_0F96);
    i_jdp_probe.set_trst(0);
    #20 chk("tdo", tdo_o, 0);
    chk("pin enables", pin_oen_o, {64{1'b1}});
    #100 i_jdp_probe.set_trst(1);
    i_jdp_probe.tlr();
    $display("Test chain done");
  endtask
  task automatic t_evt(input logic [11:0] ir, input logic [31:0] sec, input int exp);
    logic [95:0] d;
    int n0;
    @(negedge mclk_i) sec_reg_i = sec;
    i_jdp_probe.scan(1, ir, 12, d);
    n0 = n_evt;
    i_jdp_probe.scan(0, 96'hC0DE5A17, 34, d);
    repeat (30) @(negedge mclk_i);
    chk("events", n_evt - n0, exp);
    $display("Test update %h done", ir);
  endtask
  task automatic bkpt(input logic exp);
    bkpt_hit_i = 1;
    @(negedge mclk_i) bkpt_hit_i = 0;
    repeat (2) @(negedge mclk_i);
    chk("pin", debug_n_i, exp);
    dbg_exit_i = 1;
    @(negedge mclk_i) dbg_exit_i = 0;
    repeat (3) @(negedge mclk_i);
    chk("pin", debug_n_i, 1);
  endtask
  task automatic t_cap(input logic [11:0] ir, input logic [31:0] sec, input logic [31:0] exp);
    logic [95:0] d;
    @(negedge mclk_i) sec_reg_i = sec;
    i_jdp_probe.scan(1, ir, 12, d);
    i_jdp_probe.scan(0, 96'h0, 34, d);
    chk("capture", d[31:0], exp);
    $display("Test capture %h done", ir);
  endtask
  task automatic in_low(input int exp);
    int n0;
    n0 = n_evt;
    ext_n = 0;
    repeat (4) @(negedge mclk_i);
    ext_n = 1;
    repeat (8) @(negedge mclk_i);
    chk("enter", n_evt - n0, exp);
  endtask
  task automatic t_dbg();
    sec_reg_i = 0;
    dbg_out_en_i = 1;
    repeat (4) @(negedge mclk_i);
    chk("pin", debug_n_i, 1);
    bkpt(0);
    sec_reg_i[14] = 1;
    repeat (4) @(negedge mclk_i);
    bkpt(1);
    dbg_out_en_i = 0;
    dbg_in_en_i = 1;
    in_low(0);
    sec_reg_i = 0;
    repeat (4) @(negedge mclk_i);
    in_low(1);
    dbg_in_en_i = 0;
    repeat (4) @(negedge mclk_i);
    in_low(0);
    bkpt(1);
    $display("Test debug pin done");
  endtask
  initial begin
    repeat (6) @(negedge mclk_i);
    rstn_i = 1;
    t_boot();
    #300;
    t_jtag();
    t_evt(12'hFF4, 32'h0, 1);
    chk("code data", code_wr_data_o, 32'hC0DE5A17);
    t_evt(12'hFF4, 32'h1, 0);
    t_evt(12'hFF6, 32'h0, 1);
    chk("otp addr", otp_addr_o, 11'h217);
    t_evt(12'hFF6, 32'h2000, 0);
    t_evt(12'hFF5, 32'h1, 0);
    t_evt(12'hFF5, 32'h0, 1);
    @(negedge mclk_i) otp_rdata_i = 32'h5EC0_DA7A;
    otp_rvalid_i = 1;
    @(negedge mclk_i) otp_rvalid_i = 0;
    t_cap(12'hFF7, 32'h0, 32'h5EC0_DA7A);
    t_cap(12'hFF7, 32'h2000, 32'h0);
    t_cap(12'hFF9, 32'h0, 32'h3);
    t_dbg();
    tally_and_finish();
  end
endmodule
bind jdp_top jdp_asserts #(.INIT_CYCLES(INIT_CYCLES)) i_jdp_asserts (.mclk_i, .rstn_i,
  .trst_n_i, .tdo_o, .pin_oen_o, .sec_reg_i, .pll_lock_i, .boot_start_o, .code_wr_valid_o,
  .otp_rd_o, .dbg_out_en_i, .bkpt_hit_i, .debug_n_o, .debug_n_oen_o);
